// File: core/clia_alu.sv
// compare/increment/logic alu slice with its own fetch sequencer
`timescale 1ns/1ps
`include "clia_defs.svh"
module clia_alu
	import clia_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] mem_rdata,
	input wire logic [15:0] memory_pointer_pair,
	input wire logic [15:0] index_pointer_one,
	input wire logic [15:0] index_pointer_two,
	output clia_mem_s mem,
	output logic [15:0] pc,
	output logic [7:0] acc,
	output logic [7:0] reg_b,
	output logic [7:0] reg_c,
	output logic [7:0] reg_d,
	output logic [7:0] reg_e,
	output logic [7:0] reg_h,
	output logic [7:0] reg_l,
	output clia_flags_s flags,
	output logic instr_done,
	output logic illegal_op
);
	clia_state_e state, next_state;
	logic [3:0] tcnt, next_tcnt;
	logic [15:0] next_pc;
	logic [15:0] addr, next_addr;
	logic [7:0] disp, next_disp;
	logic use_two, next_use_two;
	logic [7:0] opc, next_opc;
	clia_alu_e aop, next_aop;
	logic [7:0] regs [0:7];
	logic [7:0] next_regs [0:7];
	clia_flags_s next_flags;
	logic next_done, next_illegal;
	logic last_tick;
	logic exec;
	logic [7:0] operand;
	logic [2:0] rsel;
	clia_alu_e dec_op;
	logic dec_valid, dec_inc;
	clia_src_e dec_src;

	// decode one opcode byte into operation and operand source
	function automatic void decode(input logic [7:0] b, output logic ok,
		output clia_alu_e op, output clia_src_e src, output logic inc);
		ok = 1'b1;
		op = CLIA_ALU_SBC;
		src = (b[2:0] == `CLIA_REG_MEM) ? CLIA_SRC_PTR : CLIA_SRC_REG;
		inc = 1'b0;
		if (b[7:6] == `CLIA_INC_HI && b[2:0] == `CLIA_INC_LO &&
			b[5:3] != `CLIA_REG_MEM) begin
			op = CLIA_ALU_INC;
			src = CLIA_SRC_REG;
			inc = 1'b1;
		end else if (b[7:3] == `CLIA_GRP_SBC) op = CLIA_ALU_SBC;
		else if (b[7:3] == `CLIA_GRP_AND) op = CLIA_ALU_AND;
		else if (b[7:3] == `CLIA_GRP_XOR) op = CLIA_ALU_XOR;
		else if (b[7:3] == `CLIA_GRP_OR) op = CLIA_ALU_OR;
		else if (b[7:3] == `CLIA_GRP_CMP) op = CLIA_ALU_CMP;
		else begin
			src = CLIA_SRC_IMM;
			if (b == `CLIA_OP_SBC_IMM) op = CLIA_ALU_SBC;
			else if (b == `CLIA_OP_AND_IMM) op = CLIA_ALU_AND;
			else if (b == `CLIA_OP_XOR_IMM) op = CLIA_ALU_XOR;
			else if (b == `CLIA_OP_OR_IMM) op = CLIA_ALU_OR;
			else if (b == `CLIA_OP_CMP_IMM) op = CLIA_ALU_CMP;
			else ok = 1'b0;
		end
		// register field 110 is not a register; it means memory operand
		if (!inc && src == CLIA_SRC_REG && b[2:0] == 3'h6) ok = 1'b0;
	endfunction : decode

	// the only decoder instance: the sequencer reads its outputs, so the
	// decode results keep a single driver. both fetch states look at the
	// live memory byte, because the opcode is not registered until the
	// last state of the fetch.
	always_comb begin
		decode((state == CLIA_ST_FETCH || state == CLIA_ST_PFETCH) ?
			mem_rdata : opc, dec_valid, dec_op, dec_src, dec_inc);
	end

	// register file index order matches the 3-bit field
	assign rsel = opc[2:0];
	assign acc = regs[`CLIA_REG_ACC];
	assign reg_b = regs[0];
	assign reg_c = regs[1];
	assign reg_d = regs[2];
	assign reg_e = regs[3];
	assign reg_h = regs[4];
	assign reg_l = regs[5];
	assign last_tick = (tcnt == `CLIA_TS_PER_STATE);

	// alu: computes result and flags for the operand given
	function automatic void alu(input clia_alu_e op, input logic [7:0] a,
		input logic [7:0] s, input clia_flags_s fi, output logic [7:0] r,
		output clia_flags_s fo);
		logic [8:0] d;
		logic [4:0] dl;
		d = 9'h000;
		dl = 5'h00;
		r = a;
		fo = fi;
		case (op)
			CLIA_ALU_SBC, CLIA_ALU_CMP: begin
				// compare ignores carry in; subtract-with-borrow uses it
				d = {1'b0, a} - {1'b0, s} -
					{8'h00, (op == CLIA_ALU_SBC) & fi.carry_flag};
				dl = {1'b0, a[3:0]} - {1'b0, s[3:0]} -
					{4'h0, (op == CLIA_ALU_SBC) & fi.carry_flag};
				fo.half_carry_flag = dl[4];
				fo.subtract_flag = 1'b1;
				fo.carry_flag = d[8];
				fo.parity_overflow_flag = (a[7] ^ s[7]) & (a[7] ^ d[7]);
				fo.sign_flag = d[7];
				fo.zero_flag = (d[7:0] == 8'h00);
				if (op == CLIA_ALU_SBC) r = d[7:0];
			end
			CLIA_ALU_INC: begin
				r = s + 8'h01;
				fo.half_carry_flag = (s[3:0] == 4'hF);
				fo.parity_overflow_flag = (s == `CLIA_INC_LIMIT);
				fo.subtract_flag = 1'b0;
				fo.sign_flag = r[7];
				fo.zero_flag = (r == 8'h00);
			end
			default: begin
				if (op == CLIA_ALU_AND) r = a & s;
				else if (op == CLIA_ALU_OR) r = a | s;
				else r = a ^ s;
				fo.half_carry_flag = (op == CLIA_ALU_AND);
				fo.subtract_flag = 1'b0;
				fo.carry_flag = 1'b0;
				fo.parity_overflow_flag = ~^r;
				fo.sign_flag = r[7];
				fo.zero_flag = (r == 8'h00);
			end
		endcase
	endfunction : alu

	// sequencer: each state lasts a fixed count of clock states
	always_comb begin
		logic [7:0] res;
		clia_flags_s fnew;
		res = 8'h00;
		fnew = flags;
		next_state = state;
		next_tcnt = tcnt - 4'h1;
		next_pc = pc;
		next_addr = addr;
		next_disp = disp;
		next_use_two = use_two;
		next_opc = opc;
		next_aop = aop;
		next_flags = flags;
		next_done = 1'b0;
		next_illegal = 1'b0;
		for (int i = 0; i < 8; i++) next_regs[i] = regs[i];
		exec = 1'b0;
		operand = 8'h00;
		mem = '{req: 1'b0, addr: pc};
		case (state)
			CLIA_ST_FETCH: begin
				mem = '{req: 1'b1, addr: pc};
				if (last_tick) begin
					next_pc = pc + 16'h0001;
					next_opc = mem_rdata;
					next_tcnt = `CLIA_TS_M1;
					if (mem_rdata == `CLIA_PFX_ONE ||
						mem_rdata == `CLIA_PFX_TWO) begin
						next_use_two = (mem_rdata == `CLIA_PFX_TWO);
						next_state = CLIA_ST_PFETCH;
					end else begin
						next_aop = dec_op;
						if (!dec_valid) next_illegal = 1'b1;
						else if (dec_src == CLIA_SRC_REG) begin
							// single machine cycle, execute now
							exec = 1'b1;
							operand = regs[dec_inc ? mem_rdata[5:3] :
								mem_rdata[2:0]];
							alu(dec_op, regs[`CLIA_REG_ACC], operand, flags,
								res, fnew);
							next_flags = fnew;
							if (dec_inc) next_regs[mem_rdata[5:3]] = res;
							else if (dec_op != CLIA_ALU_CMP)
								next_regs[`CLIA_REG_ACC] = res;
							next_done = 1'b1;
						end else begin
							next_addr = (dec_src == CLIA_SRC_IMM) ? next_pc :
								memory_pointer_pair;
							next_tcnt = `CLIA_TS_RD;
							next_state = CLIA_ST_READ;
						end
					end
				end
			end
			CLIA_ST_PFETCH: begin
				mem = '{req: 1'b1, addr: pc};
				if (last_tick) begin
					next_pc = pc + 16'h0001;
					next_opc = mem_rdata;
					next_aop = dec_op;
					next_tcnt = `CLIA_TS_RD;
					if (!dec_valid || dec_src != CLIA_SRC_PTR) begin
						// refused pair: the next fetch still takes all four states
						next_illegal = 1'b1;
						next_tcnt = `CLIA_TS_M1;
						next_state = CLIA_ST_FETCH;
					end else next_state = CLIA_ST_DISP;
				end
			end
			CLIA_ST_DISP: begin
				mem = '{req: 1'b1, addr: pc};
				if (last_tick) begin
					next_pc = pc + 16'h0001;
					next_disp = mem_rdata;
					next_tcnt = `CLIA_TS_ADD;
					next_state = CLIA_ST_ADDR;
				end
			end
			CLIA_ST_ADDR: begin
				// internal add of sign-extended displacement
				if (last_tick) begin
					next_addr = (use_two ? index_pointer_two :
						index_pointer_one) + {{8{disp[7]}}, disp};
					next_tcnt = `CLIA_TS_RD;
					next_state = CLIA_ST_READ;
				end
			end
			default: begin
				mem = '{req: 1'b1, addr: addr};
				if (last_tick) begin
					if (addr == pc) next_pc = pc + 16'h0001;
					exec = 1'b1;
					operand = mem_rdata;
					alu(aop, regs[`CLIA_REG_ACC], operand, flags, res, fnew);
					next_flags = fnew;
					if (aop != CLIA_ALU_CMP)
						next_regs[`CLIA_REG_ACC] = res;
					next_done = 1'b1;
					next_tcnt = `CLIA_TS_M1;
					next_state = CLIA_ST_FETCH;
				end
			end
		endcase
		if (state == CLIA_ST_FETCH && last_tick && exec)
			next_tcnt = `CLIA_TS_M1;
	end

	// all sequencer and register state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= CLIA_ST_FETCH;
			tcnt <= `CLIA_TS_M1;
			pc <= 16'h0000;
			addr <= 16'h0000;
			disp <= 8'h00;
			use_two <= 1'b0;
			opc <= 8'h00;
			aop <= CLIA_ALU_SBC;
			flags <= 8'h00;
			instr_done <= 1'b0;
			illegal_op <= 1'b0;
			for (int i = 0; i < 8; i++) regs[i] <= 8'h00;
		end else begin
			state <= next_state;
			tcnt <= next_tcnt;
			pc <= next_pc;
			addr <= next_addr;
			disp <= next_disp;
			use_two <= next_use_two;
			opc <= next_opc;
			aop <= next_aop;
			flags <= next_flags;
			instr_done <= next_done;
			illegal_op <= next_illegal;
			for (int i = 0; i < 8; i++) regs[i] <= next_regs[i];
		end
	end
endmodule : clia_alu

// File: core/clia_defs.svh
// constants for the compare/increment/logic alu slice
`ifndef CLIA_DEFS_SVH
`define CLIA_DEFS_SVH
`define CLIA_OP_SBC_IMM 8'hDE
`define CLIA_OP_SBC_PTR 8'h9E
`define CLIA_OP_AND_IMM 8'hE6
`define CLIA_OP_AND_PTR 8'hA6
`define CLIA_OP_XOR_IMM 8'hEE
`define CLIA_OP_XOR_PTR 8'hAE
`define CLIA_OP_OR_IMM 8'hF6
`define CLIA_OP_OR_PTR 8'hB6
`define CLIA_OP_CMP_IMM 8'hFE
`define CLIA_OP_CMP_PTR 8'hBE
`define CLIA_PFX_ONE 8'hDD
`define CLIA_PFX_TWO 8'hFD
`define CLIA_GRP_SBC 5'h13
`define CLIA_GRP_AND 5'h14
`define CLIA_GRP_XOR 5'h15
`define CLIA_GRP_OR 5'h16
`define CLIA_GRP_CMP 5'h17
`define CLIA_INC_HI 2'h0
`define CLIA_INC_LO 3'h4
`define CLIA_REG_MEM 3'h6
`define CLIA_REG_ACC 3'h7
`define CLIA_INC_LIMIT 8'h7F
`define CLIA_TS_M1 4'h4
`define CLIA_TS_RD 4'h3
`define CLIA_TS_ADD 4'h5
`define CLIA_TS_PER_STATE 4'h1
`define CLIA_FLAG_S 7
`define CLIA_FLAG_Z 6
`define CLIA_FLAG_H 4
`define CLIA_FLAG_PV 2
`define CLIA_FLAG_N 1
`define CLIA_FLAG_C 0
`endif

// File: core/clia_pkg.sv
// types for the compare/increment/logic alu slice
package clia_pkg;
	typedef enum logic [2:0] {
		CLIA_ALU_SBC, CLIA_ALU_AND, CLIA_ALU_XOR, CLIA_ALU_OR,
		CLIA_ALU_CMP, CLIA_ALU_INC
	} clia_alu_e;
	typedef enum logic [1:0] {
		CLIA_SRC_REG, CLIA_SRC_IMM, CLIA_SRC_PTR, CLIA_SRC_IDX
	} clia_src_e;
	typedef enum logic [2:0] {
		CLIA_ST_FETCH, CLIA_ST_PFETCH, CLIA_ST_DISP, CLIA_ST_ADDR,
		CLIA_ST_READ
	} clia_state_e;
	// condition flags as one byte: s z - h - pv n c
	typedef struct packed {
		logic sign_flag;
		logic zero_flag;
		logic unused5;
		logic half_carry_flag;
		logic unused3;
		logic parity_overflow_flag;
		logic subtract_flag;
		logic carry_flag;
	} clia_flags_s;
	// program memory request
	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} clia_mem_s;
endpackage : clia_pkg

// File: tb/clia_mem_model.sv
// program memory model feeding opcodes and operands to the alu slice
`timescale 1ns/1ps
module clia_mem_model
	import clia_pkg::*;
(
	input wire logic clk,
	input clia_mem_s mem,
	output logic [7:0] rdata
);
	logic [7:0] m [0:65535];
	logic [7:0] last;
	// bytes left at 00, which the slice must refuse
	initial begin
		for (int i = 0; i < 65536; i++) m[i] = 8'h00;
		last = 8'h00;
	end
	// an idle bus shows the inverse of the last byte, never stale data
	always @(posedge clk) begin
		if (mem.req) last <= m[mem.addr];
	end
	assign rdata = mem.req ? m[mem.addr] : ~last;
endmodule : clia_mem_model

// File: tb/clia_alu_props.sv
// assertions watching the ports of the alu slice
`timescale 1ns/1ps
module clia_alu_props
	import clia_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input clia_mem_s mem,
	input wire logic [15:0] pc,
	input wire logic [7:0] acc,
	input wire logic [7:0] reg_b,
	input wire logic [7:0] reg_c,
	input wire logic [7:0] reg_d,
	input wire logic [7:0] reg_e,
	input clia_flags_s flags,
	input wire logic instr_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shortest instruction is one machine cycle of four states
	a_done_spacing: assert property (instr_done |=> !instr_done[*3])
		else $error("completions closer than four states");
	a_acc_at_done: assert property ($changed(acc) |-> instr_done)
		else $error("accumulator moved outside completion");
	a_flags_at_done: assert property ($changed(flags) |-> instr_done)
		else $error("flags moved outside completion");
	a_sign_zero: assert property ($changed(acc) |->
		flags.zero_flag == (acc == 8'h00) && flags.sign_flag == acc[7])
		else $error("sign or zero wrong for new accumulator");
	a_fetch_next: assert property (instr_done |-> mem.req && mem.addr == pc)
		else $error("next fetch not at program counter");
	a_inc_step: assert property ($changed(reg_b) |->
		reg_b == $past(reg_b) + 8'h01)
		else $error("register changed by other than one");
	a_inc_carry: assert property ($changed(reg_c) |->
		$stable(flags.carry_flag) && !flags.subtract_flag)
		else $error("increment touched carry or subtract");
	a_inc_ovf: assert property ($changed(reg_d) |->
		flags.parity_overflow_flag == ($past(reg_d) == 8'h7F))
		else $error("increment overflow flag wrong");
	a_inc_half: assert property ($changed(reg_e) |->
		flags.half_carry_flag == (reg_e[3:0] == 4'h0))
		else $error("increment half carry wrong");
endmodule : clia_alu_props
bind clia_alu clia_alu_props u_props (.clk(clk), .resetn(resetn),
	.mem(mem), .pc(pc), .acc(acc), .reg_b(reg_b), .reg_c(reg_c),
	.reg_d(reg_d), .reg_e(reg_e), .flags(flags), .instr_done(instr_done));

// File: tb/clia_alu_test.sv
// self-checking bench running one program through the alu slice
`timescale 1ns/1ps
module clia_alu_test;
	import clia_pkg::*;
	logic clk;
	logic resetn;
	logic [7:0] mem_rdata;
	logic [15:0] memory_pointer_pair, index_pointer_one, index_pointer_two;
	clia_mem_s mem;
	logic [15:0] pc;
	logic [7:0] acc, reg_b, reg_c, reg_d, reg_e, reg_h, reg_l;
	clia_flags_s flags;
	logic instr_done, illegal_op;
	int n_fail = 0;
	int samples_checked = 0;
	// program ends in 00, an opcode the slice must skip
	logic [7:0] prog [30] = '{8'hF6, 8'h12, 8'h04, 8'hEE, 8'h0F, 8'hA0,
		8'hDE, 8'h01, 8'h9E, 8'h0C, 8'hDD, 8'h9E, 8'h02, 8'hFD, 8'hBE,
		8'hFE, 8'hE6, 8'h7F, 8'hF6, 8'h0F, 8'h3C, 8'hA7, 8'hB7, 8'hAF,
		8'hBF, 8'h14, 8'h1C, 8'h24, 8'h2C, 8'h00};
	clia_alu uut (.clk(clk), .resetn(resetn), .mem_rdata(mem_rdata),
		.memory_pointer_pair(memory_pointer_pair),
		.index_pointer_one(index_pointer_one),
		.index_pointer_two(index_pointer_two), .mem(mem), .pc(pc),
		.acc(acc), .reg_b(reg_b), .reg_c(reg_c), .reg_d(reg_d),
		.reg_e(reg_e), .reg_h(reg_h), .reg_l(reg_l), .flags(flags),
		.instr_done(instr_done), .illegal_op(illegal_op));
	clia_mem_model mdl (.clk(clk), .mem(mem), .rdata(mem_rdata));
	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// waits for the next completion; ec of 0 skips the state count
	task automatic step(input logic [7:0] ea, input logic [7:0] ef,
		input int ec);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (instr_done !== 1'b1 && n < 40);
		chk("done", 16'h0001, {15'h0000, instr_done});
		chk("acc", ea, acc);
		chk("flags", ef, flags);
		if (ec != 0) chk("states", ec[15:0], n[15:0]);
	endtask : step
	task automatic t_logic;
		step(8'h12, 8'h04, 0);
		step(8'h12, 8'h00, 4);
		step(8'h1D, 8'h04, 7);
		step(8'h01, 8'h10, 4);
	endtask : t_logic
	task automatic t_borrow;
		step(8'h00, 8'h42, 7);
		step(8'hFF, 8'h93, 7);
		step(8'hFF, 8'h01, 4);
		step(8'hF0, 8'h82, 19);
		chk("reg_bc", 16'h0101, {reg_b, reg_c});
	endtask : t_borrow
	// negative displacement off the second index register
	task automatic t_cmp_index;
		step(8'hF0, 8'h16, 19);
	endtask : t_cmp_index
	task automatic t_overflow;
		step(8'h70, 8'h10, 7);
		step(8'h7F, 8'h00, 7);
		step(8'h80, 8'h94, 4);
	endtask : t_overflow
	task automatic t_acc_field;
		step(8'h80, 8'h90, 4);
		step(8'h80, 8'h80, 4);
		step(8'h00, 8'h44, 4);
		step(8'h00, 8'h42, 4);
	endtask : t_acc_field
	task automatic t_reg_fields;
		for (int i = 0; i < 4; i++) step(8'h00, 8'h00, 4);
		chk("reg_de", 16'h0101, {reg_d, reg_e});
		chk("reg_hl", 16'h0101, {reg_h, reg_l});
	endtask : t_reg_fields
	task automatic t_refuse;
		int n;
		n = 0;
		while (illegal_op !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("illegal_op", 16'h0001, {15'h0000, illegal_op});
		chk("pc", 16'h001E, pc);
	endtask : t_refuse
	task automatic summarize;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// pointer pair and index registers aim at the operand bytes
	initial begin
		resetn = 1'b0;
		memory_pointer_pair = 16'h0200;
		index_pointer_one = 16'h0300;
		index_pointer_two = 16'h0400;
		#1;
		for (int i = 0; i < 30; i++) mdl.m[i] = prog[i];
		mdl.m[16'h0200] = 8'h01;
		mdl.m[16'h0302] = 8'h0E;
		mdl.m[16'h03FE] = 8'h71;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		t_logic();
		t_borrow();
		t_cmp_index();
		t_overflow();
		t_acc_field();
		t_reg_fields();
		t_refuse();
		summarize();
	end
	// the program needs well under a thousand cycles
	initial begin
		#20000;
		n_fail++;
		summarize();
	end
endmodule : clia_alu_test
